/* dv/mac_partner.sv */
/* behavioural mac on the far side of mac-side negotiation.
   assumes restart is a one-cycle pulse from the bank. */
module mac_partner
    import phy_regs_pkg::*;
#(
    parameter int              DELAY   = 4,
    parameter mac_ability_type ABILITY = 6'h2a
)
(
    input  wire logic      clk,
    input  wire logic      restart,
    input  wire logic      if_enable,
    output mac_status_type status
);
    timeunit 1ns;
    timeprecision 1ps;
    int count = 0;
    // negotiation reruns after a restart or while the interface is held off
    always @(posedge clk) begin
        if (restart || !if_enable) count <= DELAY;
        else if (count > 0) count <= count - 1;
    end
    // nothing reported until done, so stale abilities never leak
    assign status = (count == 0 && if_enable) ? {ABILITY, 3'h7} : '0;
endmodule

/* dv/regs_chk.sv */
/* checker for the phy port register bank: bus answers, status reads, restart.
   assumes a bind to the bank top and sight of its ports only. */
module regs_chk
    import phy_regs_pkg::*;
(
    input wire logic          SYS_CLK,
    input wire logic          RST_N,
    input wire logic          SOFT_RESET,
    input wire logic [15:0]   PAGE_SELECT,
    input wire logic [4:0]    REG_ADDR,
    input wire logic          REG_WRITE,
    input wire logic          REG_READ,
    input wire logic [15:0]   REG_WDATA,
    input wire irq_event_type IRQ_EVENTS,
    input wire logic          MEDIA_LINK_UP,
    input wire logic [15:0]   REG_RDATA,
    input wire logic          REG_HIT,
    input wire logic          MAC_NEG_RESTART,
    input wire logic          MAC_IF_ENABLE
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // decoded accesses
    // ------------------------------
    wire logic main_pg = PAGE_SELECT == MAIN_PAGE;
    wire logic hit     = (REG_READ || REG_WRITE) && main_pg && REG_ADDR inside {[5'h18:5'h1b]};
    wire logic rd_st   = REG_READ && main_pg && REG_ADDR == 5'h1a;
    // soft reset excluded, though a same-cycle restart write still gives the pulse
    wire logic rst_wr  = REG_WRITE && main_pg && REG_ADDR == 5'h1b && REG_WDATA[12] && !SOFT_RESET;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    bank_hit_a: assert property (hit |=> REG_HIT)
        else $error("bank access not answered");
    page_miss_a: assert property ((REG_READ || REG_WRITE) && !main_pg |=> !REG_HIT && REG_RDATA == 16'h0000)
        else $error("access on another page answered");
    idle_data_a: assert property (!REG_READ |=> REG_RDATA == 16'h0000)
        else $error("read data without a read");
    pending_sum_a: assert property (rd_st |=> REG_RDATA[15] == (|REG_RDATA[14:0]))
        else $error("pending bit disagrees with sources");
    read_clear_a: assert property ((rd_st && IRQ_EVENTS == '0) ##1 (rd_st && IRQ_EVENTS == '0) |=> REG_RDATA == 16'h0000)
        else $error("status not cleared by read");
    same_cycle_a: assert property ((rd_st && IRQ_EVENTS.media) ##1 rd_st |=> REG_RDATA[4])
        else $error("event lost during clearing read");
    restart_pulse_a: assert property (rst_wr |=> MAC_NEG_RESTART)
        else $error("restart write gave no pulse");
    link_enable_a: assert property (MEDIA_LINK_UP |=> MAC_IF_ENABLE)
        else $error("mac interface off with link up");
    cover property (rd_st ##1 REG_RDATA != 16'h0000);
    cover property (MAC_NEG_RESTART);
    cover property (!MAC_IF_ENABLE);
endmodule
bind phy_ext_ctrl_irq_mac_aneg_regs regs_chk chk (.*);

/* dv/test_phy_ext_ctrl_irq_mac_aneg_regs.sv */
/* self-checking bench for the phy port register bank.
   assumes the package, the bank, the checker and the mac partner model. */
module test_phy_ext_ctrl_irq_mac_aneg_regs;
    import phy_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic           SYS_CLK = 0, RST_N = 0, SOFT_RESET = 0, STICKY_RESET_ENABLE = 1;
    logic           REG_WRITE = 0, REG_READ = 0, COPPER_ANEG_ENABLE = 0, MEDIA_LINK_UP = 1;
    logic [15:0]    PAGE_SELECT = 16'h0000, REG_WDATA = 16'h0000, REG_RDATA;
    logic [4:0]     REG_ADDR = 5'h00;
    logic [3:0]     ADVERTISE_BITS = 4'h0;
    irq_event_type  IRQ_EVENTS = '0;
    mac_status_type MAC_STATUS;
    logic           REG_HIT, INTERRUPT_REQUEST_PIN_N, REDUCED_POWER, OUT_PREAMBLE_ON, CONNECTOR_LOOPBACK;
    logic           MAC_AUTOSENSE, MAC_NEG_RESTART, MAC_IF_ENABLE;
    logic [2:0]     EDGE_RATE, TX_AMPLITUDE;
    logic [1:0]     IN_PREAMBLE_BYTES, MAX_PACKET_LENGTH;
    int             errors = 0, compares = 0;
    phy_ext_ctrl_irq_mac_aneg_regs uut (.*);
    mac_partner peer (.clk(SYS_CLK), .restart(MAC_NEG_RESTART), .if_enable(MAC_IF_ENABLE), .status(MAC_STATUS));
    always #12.5 SYS_CLK = ~SYS_CLK;
    // ------------------------------
    // shared helpers
    // ------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle; a read compares the masked answer with d
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [15:0] m = 16'hffff);
        @(negedge SYS_CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WRITE = w;
        REG_READ = !w;
        @(negedge SYS_CLK);
        {REG_WRITE, REG_READ} = 2'b00;
        if (!w) chk(REG_RDATA & m, d);
    endtask
    task automatic ev(input irq_event_type e);
        @(negedge SYS_CLK);
        IRQ_EVENTS = e;
        @(negedge SYS_CLK);
        IRQ_EVENTS = '0;
    endtask
    task automatic sr(input logic keep);
        @(negedge SYS_CLK);
        STICKY_RESET_ENABLE = keep;
        SOFT_RESET = 1;
        @(negedge SYS_CLK);
        SOFT_RESET = 0;
    endtask
    // counting over a window: the checker times only the write-driven restart pulse
    task automatic pulses(input logic [15:0] exp);
        logic [15:0] n;
        n = 0;
        repeat (4) begin
            @(negedge SYS_CLK);
            n += 16'(MAC_NEG_RESTART);
        end
        chk(n, exp);
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_ext();
        acc(0, 5'h18, 16'hc040);
        acc(0, 5'h19, 16'h0000);
        acc(0, 5'h1b, 16'h0000, 16'hf000);
        acc(1, 5'h18, 16'hffff);
        acc(0, 5'h18, 16'hf04f);
        // reserved codes refused at the field outputs too; loose bits set
        chk(16'({REDUCED_POWER, CONNECTOR_LOOPBACK, IN_PREAMBLE_BYTES, MAX_PACKET_LENGTH}), 16'h0030);
        acc(1, 5'h18, 16'h8122);
        chk({EDGE_RATE, IN_PREAMBLE_BYTES, OUT_PREAMBLE_ON, MAX_PACKET_LENGTH, TX_AMPLITUDE, 5'h00}, 16'h9220);
        PAGE_SELECT = 16'h0001;
        acc(1, 5'h18, 16'h0000);
        acc(0, 5'h18, 16'h0000);
        PAGE_SELECT = 16'h0000;
        sr(1);
        acc(0, 5'h18, 16'h8120);
        sr(0);
        acc(0, 5'h18, 16'hc040);
    endtask
    task automatic t_irq();
        acc(1, 5'h19, 16'hffff);
        acc(0, 5'h19, 16'hfe16);
        ev(9'h180);
        acc(0, 5'h1a, 16'ha000);
        acc(0, 5'h1a, 16'h0000);
        COPPER_ANEG_ENABLE = 1;
        ev(9'h142);
        acc(0, 5'h1a, 16'hd000);
        ADVERTISE_BITS = 4'hf;
        ev(9'h002);
        acc(0, 5'h1a, 16'h8004);
        ev(9'h080);
        @(negedge SYS_CLK);
        chk(INTERRUPT_REQUEST_PIN_N, 16'h0000);
        acc(1, 5'h19, 16'h7e16);
        @(negedge SYS_CLK);
        chk(INTERRUPT_REQUEST_PIN_N, 16'h0001);
        acc(0, 5'h1a, 16'ha000);
        // event lands in the very cycle of a clearing read
        @(negedge SYS_CLK);
        REG_ADDR = 5'h1a;
        REG_READ = 1;
        IRQ_EVENTS = 9'h004;
        @(negedge SYS_CLK);
        IRQ_EVENTS = '0;
        @(negedge SYS_CLK);
        chk(REG_RDATA, 16'h8010);
        // read held a third cycle: the second clear leaves nothing behind
        @(negedge SYS_CLK);
        REG_READ = 0;
        chk(REG_RDATA, 16'h0000);
    endtask
    task automatic t_mac();
        acc(1, 5'h1b, 16'h1000);
        repeat (8) @(negedge SYS_CLK);
        acc(0, 5'h1b, 16'h02ae);
        acc(1, 5'h1b, 16'he000);
        chk(MAC_AUTOSENSE, 16'h0001);
        MEDIA_LINK_UP = 0;
        pulses(16'h0001);
        chk(MAC_IF_ENABLE, 16'h0000);
        acc(1, 5'h1b, 16'h2000);
        @(negedge SYS_CLK);
        chk(MAC_IF_ENABLE, 16'h0001);
        MEDIA_LINK_UP = 1;
        pulses(16'h0000);
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge SYS_CLK);
        RST_N = 1;
        t_ext();
        t_irq();
        t_mac();
        test_done();
    end
    // watchdog: the whole run needs under a hundred cycles
    initial begin
        #(25ns * 4000);
        errors++;
        test_done();
    end
endmodule

/* hdl/irq_status_reg.sv */
/*
 * clear-on-read interrupt status register with its pending summary.
 * assumes the read strobe is one cycle long and events are single pulses.
 */
module irq_status_reg
    import phy_regs_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire irq_event_type events,
    input  wire logic          aneg_enabled,
    input  wire logic          downshift_allowed,
    input  wire logic          read_clear,
    output logic [15:0]        status
);

    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic [15:0] raw_set;
    logic [15:0] sources;

    // ------------------------------------------------------------------
    // event qualification
    // ------------------------------------------------------------------
    assign raw_set[IRQ_PENDING_BIT]   = 1'b0;
    assign raw_set[IRQ_SPEED_BIT]     = events.speed && aneg_enabled;
    assign raw_set[IRQ_LINK_BIT]      = events.link;
    assign raw_set[IRQ_DUPLEX_BIT]    = events.duplex && aneg_enabled;
    assign raw_set[IRQ_NEG_ERR_BIT]   = events.neg_err;
    assign raw_set[IRQ_NEG_DONE_BIT]  = events.neg_done;
    assign raw_set[IRQ_PWR_DEV_BIT]   = events.pwr_dev;
    assign raw_set[8:5]               = 4'h0;
    assign raw_set[IRQ_MEDIA_BIT]     = events.media;
    assign raw_set[3]                 = 1'b0;
    assign raw_set[IRQ_DOWNSHIFT_BIT] = events.downshift && downshift_allowed;
    assign raw_set[IRQ_MS_ERR_BIT]    = events.ms_err;
    assign raw_set[0]                 = 1'b0;

    // a read clears what it saw; a same-cycle event sets again
    assign sources = ((read_clear ? 16'h0000 : status_reg) | raw_set) & IRQ_SOURCE_MASK;
    assign status_next = {|sources, sources[14:0]};

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_reg <= 16'h0000;
        end else begin
            status_reg <= status_next;
        end
    end

    assign status = status_reg;

endmodule

/* hdl/mac_neg_ctrl.sv */
/*
 * mac-side negotiation control: restart request, link-change restart and
 * the mac interface enable. assumes the serdes engine acknowledges nothing;
 * a restart is a single pulse to it.
 */
module mac_neg_ctrl
    import phy_regs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic restart_write,
    input  wire logic restart_on_change,
    input  wire logic interlock,
    input  wire logic media_link_up,
    output logic      restart_pulse,
    output logic      mac_if_enable
);

    logic link_seen_reg;
    logic restart_reg;
    logic enable_reg;
    logic link_changed;

    // ------------------------------------------------------------------
    // link change detect and restart
    // ------------------------------------------------------------------
    assign link_changed = link_seen_reg != media_link_up;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_seen_reg <= 1'b0;
            restart_reg   <= 1'b0;
            enable_reg    <= 1'b0;
        end else begin
            link_seen_reg <= media_link_up;
            restart_reg   <= restart_write || (restart_on_change && link_changed);
            enable_reg    <= !interlock || media_link_up;
        end
    end

    assign restart_pulse = restart_reg;
    assign mac_if_enable = enable_reg;

endmodule

/* hdl/phy_ext_ctrl_irq_mac_aneg_regs.sv */
/*
 * register bank for one phy port, main registers 24 to 27: second extended
 * control, interrupt mask, clear-on-read interrupt status and mac-side
 * negotiation control/status, plus the interrupt request pin.
 * assumes the management interface presents one-cycle read and write
 * strobes with a register number, write data and the current page value,
 * all synchronous to SYS_CLK; read data is taken one cycle after the strobe.
 */
// What this block does
// - edge rate field resets to nominal 110
// - input preamble field, 00 reset, 11 reserved
// - output preamble bit resets to one
// - packet length field selects 1.5/9/12 kB
// - jumbo limits assume 100 ppm reference clock
// - transmit amplitude field resets to nominal 000
// - one mask bit per interrupt source, only bit 15 gates the pin
// - pin follows pending bit when enabled
// - status register clears on host read
// - bit 15 pending, lower bits name source
// - speed/duplex events need copper negotiation enabled
// - downshift event needs advertisement bits 8:5
// - interlock disables mac interface on link-down
// - restart mac negotiation on link change
// - auto-sense links with any mac
// - restart bit self-clears after starting negotiation
// - mac abilities captured read-only
// - mac capable, link and done status
// - sticky fields survive soft reset when enabled
// - bank reachable only on main page
module phy_ext_ctrl_irq_mac_aneg_regs
    import phy_regs_pkg::*;
(
    input  wire logic           SYS_CLK,
    input  wire logic           RST_N,
    input  wire logic           SOFT_RESET,
    input  wire logic           STICKY_RESET_ENABLE,
    input  wire logic [15:0]    PAGE_SELECT,
    input  wire logic [4:0]     REG_ADDR,
    input  wire logic           REG_WRITE,
    input  wire logic           REG_READ,
    input  wire logic [15:0]    REG_WDATA,
    input  wire irq_event_type  IRQ_EVENTS,
    input  wire logic           COPPER_ANEG_ENABLE,
    input  wire logic [3:0]     ADVERTISE_BITS,
    input  wire logic           MEDIA_LINK_UP,
    input  wire mac_status_type MAC_STATUS,
    output logic [15:0]         REG_RDATA,
    output logic                REG_HIT,
    output logic                INTERRUPT_REQUEST_PIN_N,
    output logic [2:0]          EDGE_RATE,
    output logic                REDUCED_POWER,
    output logic [1:0]          IN_PREAMBLE_BYTES,
    output logic                OUT_PREAMBLE_ON,
    output logic [1:0]          MAX_PACKET_LENGTH,
    output logic [2:0]          TX_AMPLITUDE,
    output logic                CONNECTOR_LOOPBACK,
    output logic                MAC_AUTOSENSE,
    output logic                MAC_NEG_RESTART,
    output logic                MAC_IF_ENABLE
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [15:0] ext_ctrl_reg;
    logic [15:0] ext_ctrl_next;
    logic [15:0] mask_reg;
    logic [15:0] mask_next;
    logic [2:0]  mac_ctrl_reg;
    logic [2:0]  mac_ctrl_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        hit_reg;
    logic        pin_n_reg;
    logic        restart_bit_reg;
    logic        restart_bit_next;
    logic [15:0] status;
    logic        restart_pulse;
    logic        mac_if_enable;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire         main_page   = PAGE_SELECT == MAIN_PAGE;
    wire         hit_ext     = main_page && REG_ADDR == EXT_CTRL_TWO_ADDR;
    wire         hit_mask    = main_page && REG_ADDR == IRQ_MASK_ADDR;
    wire         hit_status  = main_page && REG_ADDR == IRQ_STATUS_ADDR;
    wire         hit_mac     = main_page && REG_ADDR == MAC_NEG_ADDR;
    wire         any_hit     = hit_ext || hit_mask || hit_status || hit_mac;
    wire         wr_ext      = REG_WRITE && hit_ext;
    wire         wr_mask     = REG_WRITE && hit_mask;
    wire         wr_mac      = REG_WRITE && hit_mac;
    wire         rd_status   = REG_READ && hit_status;
    // sticky fields lose their values only when the enable is clear
    wire         soft_clear  = SOFT_RESET && !STICKY_RESET_ENABLE;

    // ------------------------------------------------------------------
    // field writes; reserved codes of the two-bit fields are refused so
    // the downstream datapath never sees an undefined mode
    // ------------------------------------------------------------------
    function automatic logic [1:0] keep_legal(input logic [1:0] new_code,
                                              input logic [1:0] old_code);
        keep_legal = (new_code == CODE_RESERVED) ? old_code : new_code;
    endfunction

    wire [15:0]  ext_written = (REG_WDATA & EXT_CTRL_TWO_WMASK) | (ext_ctrl_reg & ~EXT_CTRL_TWO_WMASK);
    wire [1:0]   in_pre_new  = keep_legal(ext_written[IN_PREAMBLE_LSB +: 2],
                                          ext_ctrl_reg[IN_PREAMBLE_LSB +: 2]);
    wire [1:0]   pkt_len_new = keep_legal(ext_written[PKT_LEN_LSB +: 2],
                                          ext_ctrl_reg[PKT_LEN_LSB +: 2]);
    // the whole register is sticky except the amplitude and loopback bits
    wire [15:0]  ext_reset   = {EDGE_RATE_RESET, 1'b0, 3'h0, IN_PREAMBLE_RESET,
                                OUT_PREAMBLE_RESET, PKT_LEN_RESET, TX_AMP_RESET, 1'b0};

    always_comb begin
        ext_ctrl_next = ext_ctrl_reg;
        if (wr_ext) begin
            ext_ctrl_next = {ext_written[15:9], in_pre_new, ext_written[6],
                             pkt_len_new, ext_written[3:0]};
        end
        if (SOFT_RESET) begin
            // amplitude and loopback are not sticky
            ext_ctrl_next[3:0] = {TX_AMP_RESET, 1'b0};
            if (soft_clear) begin
                ext_ctrl_next = ext_reset;
            end
        end
    end

    // mask register: sticky bits survive soft reset when enabled
    always_comb begin
        mask_next = mask_reg;
        if (wr_mask) begin
            mask_next = REG_WDATA & IRQ_MASK_WMASK;
        end
        if (SOFT_RESET) begin
            mask_next = soft_clear ? IRQ_MASK_RESET
                                   : (mask_next & IRQ_MASK_STICKY);
        end
    end

    // mac negotiation control bits 15:13 are sticky
    always_comb begin
        mac_ctrl_next = mac_ctrl_reg;
        if (wr_mac) begin
            mac_ctrl_next = REG_WDATA[MAC_AUTOSENSE_BIT +: 3];
        end
        if (soft_clear) begin
            mac_ctrl_next = MAC_CTRL_RESET;
        end
    end

    // restart bit reads 1 for the cycle the request is taken, then clears
    assign restart_bit_next = wr_mac && REG_WDATA[MAC_RESTART_BIT];

    // ------------------------------------------------------------------
    // read mux; the status read happens before its own clear lands
    // ------------------------------------------------------------------
    wire [15:0]  mac_word = {mac_ctrl_reg, restart_bit_reg, 2'h0,
                             MAC_STATUS.ability, MAC_STATUS.capable,
                             MAC_STATUS.link_up, MAC_STATUS.done, 1'b0};

    always_comb begin
        rdata_next = 16'h0000;
        if (REG_READ) begin
            case (1'b1)
                hit_ext:    rdata_next = ext_ctrl_reg;
                hit_mask:   rdata_next = mask_reg;
                hit_status: rdata_next = status;
                hit_mac:    rdata_next = mac_word;
                default:    rdata_next = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // clocked state
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ext_ctrl_reg    <= ext_reset;
            mask_reg        <= IRQ_MASK_RESET;
            mac_ctrl_reg    <= MAC_CTRL_RESET;
            restart_bit_reg <= 1'b0;
        end else begin
            ext_ctrl_reg    <= ext_ctrl_next;
            mask_reg        <= mask_next;
            mac_ctrl_reg    <= mac_ctrl_next;
            restart_bit_reg <= restart_bit_next;
        end
    end

    // bus answer and pin, registered so every output leaves a flop
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rdata_reg <= 16'h0000;
            hit_reg   <= 1'b0;
            pin_n_reg <= 1'b1;
        end else begin
            rdata_reg <= rdata_next;
            hit_reg   <= (REG_READ || REG_WRITE) && any_hit;
            // masking only gates the pin, the status keeps its bits
            pin_n_reg <= !(mask_reg[IRQ_PENDING_BIT] && status[IRQ_PENDING_BIT]);
        end
    end

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    irq_status_reg u_status (
        .clk               (SYS_CLK),
        .rst_n             (RST_N),
        .events            (IRQ_EVENTS),
        .aneg_enabled      (COPPER_ANEG_ENABLE),
        .downshift_allowed (&ADVERTISE_BITS),
        .read_clear        (rd_status),
        .status            (status)
    );

    mac_neg_ctrl u_mac (
        .clk               (SYS_CLK),
        .rst_n             (RST_N),
        .restart_write     (restart_bit_next),
        .restart_on_change (mac_ctrl_reg[1]),
        .interlock         (mac_ctrl_reg[2]),
        .media_link_up     (MEDIA_LINK_UP),
        .restart_pulse     (restart_pulse),
        .mac_if_enable     (mac_if_enable)
    );

    // ------------------------------------------------------------------
    // outputs; the jumbo limit assumes a 100 ppm reference, a tighter
    // clock only lets the mac side accept longer frames
    // ------------------------------------------------------------------
    assign REG_RDATA               = rdata_reg;
    assign REG_HIT                 = hit_reg;
    assign INTERRUPT_REQUEST_PIN_N = pin_n_reg;
    assign EDGE_RATE               = ext_ctrl_reg[EDGE_RATE_LSB +: 3];
    assign REDUCED_POWER           = ext_ctrl_reg[REDUCED_PWR_BIT];
    assign IN_PREAMBLE_BYTES       = ext_ctrl_reg[IN_PREAMBLE_LSB +: 2];
    assign OUT_PREAMBLE_ON         = ext_ctrl_reg[OUT_PREAMBLE_BIT];
    assign MAX_PACKET_LENGTH       = ext_ctrl_reg[PKT_LEN_LSB +: 2];
    assign TX_AMPLITUDE            = ext_ctrl_reg[TX_AMP_LSB +: 3];
    assign CONNECTOR_LOOPBACK      = ext_ctrl_reg[CONN_LOOPBACK_BIT];
    assign MAC_AUTOSENSE           = mac_ctrl_reg[0];
    assign MAC_NEG_RESTART         = restart_pulse;
    assign MAC_IF_ENABLE           = mac_if_enable;

endmodule

/* shared/phy_regs_pkg.sv */
/*
 * package for the port register bank covering main registers 24 to 27:
 * addresses, field positions, reset values and the carrier structs.
 * assumes a 5-bit register number and 16-bit data from the management port.
 */
package phy_regs_pkg;

    // ------------------------------------------------------------------
    // register numbers and page selection
    // ------------------------------------------------------------------
    localparam logic [4:0]  EXT_CTRL_TWO_ADDR  = 5'h18;
    localparam logic [4:0]  IRQ_MASK_ADDR      = 5'h19;
    localparam logic [4:0]  IRQ_STATUS_ADDR    = 5'h1a;
    localparam logic [4:0]  MAC_NEG_ADDR       = 5'h1b;
    localparam logic [15:0] MAIN_PAGE          = 16'h0000;

    // ------------------------------------------------------------------
    // second extended control fields
    // ------------------------------------------------------------------
    localparam int          EDGE_RATE_LSB      = 13;
    localparam int          REDUCED_PWR_BIT    = 12;
    localparam int          IN_PREAMBLE_LSB    = 7;
    localparam int          OUT_PREAMBLE_BIT   = 6;
    localparam int          PKT_LEN_LSB        = 4;
    localparam int          TX_AMP_LSB         = 1;
    localparam int          CONN_LOOPBACK_BIT  = 0;
    localparam logic [2:0]  EDGE_RATE_RESET    = 3'h6;
    localparam logic [1:0]  IN_PREAMBLE_RESET  = 2'h0;
    localparam logic        OUT_PREAMBLE_RESET = 1'b1;
    localparam logic [1:0]  PKT_LEN_RESET      = 2'h0;
    localparam logic [2:0]  TX_AMP_RESET       = 3'h0;
    localparam logic [1:0]  CODE_RESERVED      = 2'h3;
    // writable bits of register 24 (11:9 reserved)
    localparam logic [15:0] EXT_CTRL_TWO_WMASK = 16'hf1ff;

    // ------------------------------------------------------------------
    // interrupt mask / status layout
    // ------------------------------------------------------------------
    localparam int          IRQ_PENDING_BIT    = 15;
    localparam int          IRQ_SPEED_BIT      = 14;
    localparam int          IRQ_LINK_BIT       = 13;
    localparam int          IRQ_DUPLEX_BIT     = 12;
    localparam int          IRQ_NEG_ERR_BIT    = 11;
    localparam int          IRQ_NEG_DONE_BIT   = 10;
    localparam int          IRQ_PWR_DEV_BIT    = 9;
    localparam int          IRQ_MEDIA_BIT      = 4;
    localparam int          IRQ_DOWNSHIFT_BIT  = 2;
    localparam int          IRQ_MS_ERR_BIT     = 1;
    localparam logic [15:0] IRQ_SOURCE_MASK    = 16'h7e16;
    localparam logic [15:0] IRQ_MASK_WMASK     = 16'hfe16;
    localparam logic [15:0] IRQ_MASK_RESET     = 16'h0000;
    // mask bits kept across soft reset (negotiation error bit is not sticky)
    localparam logic [15:0] IRQ_MASK_STICKY    = 16'hf616;

    // ------------------------------------------------------------------
    // mac-side negotiation register
    // ------------------------------------------------------------------
    localparam int          MAC_INTERLOCK_BIT  = 15;
    localparam int          MAC_RESTART_IL_BIT = 14;
    localparam int          MAC_AUTOSENSE_BIT  = 13;
    localparam int          MAC_RESTART_BIT    = 12;
    localparam int          MAC_ABIL_LSB       = 4;
    localparam int          MAC_CAPABLE_BIT    = 3;
    localparam int          MAC_LINK_BIT       = 2;
    localparam int          MAC_DONE_BIT       = 1;
    localparam logic [2:0]  MAC_CTRL_RESET     = 3'h0;

    // events seen by the status register, one bit per source position
    typedef struct packed {
        logic speed;
        logic link;
        logic duplex;
        logic neg_err;
        logic neg_done;
        logic pwr_dev;
        logic media;
        logic downshift;
        logic ms_err;
    } irq_event_type;

    // abilities reported by the mac during negotiation
    typedef struct packed {
        logic [1:0] remote_fault;
        logic       asym_pause;
        logic       sym_pause;
        logic       full_duplex;
        logic       half_duplex;
    } mac_ability_type;

    // mac-side negotiation status from the serdes engine
    typedef struct packed {
        mac_ability_type ability;
        logic            capable;
        logic            link_up;
        logic            done;
    } mac_status_type;

endpackage
